//--- logic/inc_pkg.sv
// shared constants for the configuration access link: register space, timing, host register map
package inc_pkg;
  localparam int         NUM_REGS          = 11;
  localparam logic [7:0] NUM_REGS_B        = 8'h0b;
  localparam logic [7:0] IDX_VOUT_LAST     = 8'h02;
  localparam logic [3:0] IDX_FREQ_PHASE    = 4'h9;
  localparam logic [3:0] IDX_PWR           = 4'ha;
  localparam int         PHASE_MSB         = 6;
  localparam int         PHASE_LSB         = 5;
  localparam int         UVLO_BIT          = 6;
  localparam logic [5:0] TARGET_ADDR_FIXED = 6'h3a;
  localparam logic [7:0] NVM_DEFAULT [NUM_REGS] = '{8'h00, 8'h00, 8'h00, 8'h15, 8'h15, 8'h15,
                                                    8'h05, 8'h05, 8'h05, 8'h42, 8'h7f};
  localparam int         CLK_HZ            = 100_000_000;
  localparam int         NVM_LOAD_US       = 200;
  localparam int         NVM_LOAD_CYCLES   = NVM_LOAD_US * (CLK_HZ / 1_000_000);
  localparam int         NVM_GAP_MS        = 100;
  localparam int         NVM_GAP_CYCLES    = NVM_GAP_MS * (CLK_HZ / 1000);
  localparam int         SCL_MAX_KHZ       = 400;
  localparam int         SCL_QUARTER_CYCLES = (CLK_HZ / 1000 + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);
  localparam logic [7:0] HOST_CMD_OFS      = 8'h00;
  localparam logic [7:0] HOST_INDEX_OFS    = 8'h04;
  localparam logic [7:0] HOST_WDATA_OFS    = 8'h08;
  localparam logic [7:0] HOST_STATUS_OFS   = 8'h0c;
  localparam int         CMD_GO_BIT        = 0;
  localparam int         CMD_READ_BIT      = 1;
  localparam int         CMD_STORAGE_BIT   = 2;
  localparam int         CMD_ASEL_BIT      = 3;
  localparam int         STAT_BUSY_BIT     = 0;
  localparam int         STAT_NACK_BIT     = 1;
  localparam int         STAT_REFUSED_BIT  = 2;
  localparam int         STAT_READY_BIT    = 3;
  localparam int         STAT_RDATA_LSB    = 8;
endpackage

//--- logic/inc_if.sv
// two-wire link between the host master and the configuration target, open-drain resolved here
interface inc_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

//--- logic/inc_dev.sv
// configuration target: two-wire slave, storage and run-time register banks, power-on load
//
// Overview of operation
// RULE1: storage select low, supply good: write storage; the target here also needs enable low
// RULE2: supply low: storage writes ignored
// RULE3: write accepted right after select goes low
// RULE4: host spaces storage writes 100ms apart
// RULE5: storage write also copies into run-time register
// RULE6: select high: writes go to run-time only
// RULE7: select high: offsets above 02h need enable low
// RULE8: select high: offsets up to 02h always writable
// RULE9: host writes storage only enable low, supply good
// RULE10: select high: reads return run-time registers
// RULE11: select low: reads return storage contents
// RULE12: host reads storage only while enable low
// RULE13: power-on copies storage to run-time, 200us
// RULE14: link works up to 400kHz clock
// RULE15: matching address acknowledged on ninth clock
// RULE16: register index byte follows address byte
// RULE17: register 09h bits 6:5 pick phase arrangement
// RULE18: UVLO threshold choice, 7V or 4.2V
// RULE19: address is 111010 plus address-select pin
// RULE20: read: index write, repeated start, read, NACK
// RULE21: modes latched at start; bad writes discarded
module inc_dev
  import inc_pkg::*;
#(
  parameter int LOAD_CYCLES = NVM_LOAD_CYCLES
) (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  inc_if.dev              link,
  input  wire logic       chip_enable_in,
  input  wire logic       supply_adequate_in,
  input  wire logic       storage_write_select_n_in,
  input  wire logic       target_address_select_in,
  output logic [1:0]      phase_select_out,
  output logic            uvlo_low_select_out,
  output logic            config_ready_out
);

  localparam int LW = $clog2(LOAD_CYCLES + 1);

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_INDEX, S_INDEX_ACK, S_WDATA, S_WDATA_ACK, S_RDATA, S_RACK
  } inc_dstate_e;

  inc_dstate_e    state_reg;
  logic [5:0]     sync1_reg;
  logic [5:0]     sync2_reg;
  logic           scl_prev_reg;
  logic           sda_prev_reg;
  logic [3:0]     cnt_reg;
  logic [7:0]     shift_reg;
  logic [7:0]     tx_reg;
  logic [7:0]     idx_reg;
  logic [7:0]     wr_data_reg;
  logic           wr_stb_reg;
  logic           rw_reg;
  logic           storage_mode_reg;
  logic           enable_t_reg;
  logic           supply_t_reg;
  logic [LW-1:0]  load_cnt_reg;
  logic [7:0]     nvm_mem [NUM_REGS];
  logic [7:0]     run_mem [NUM_REGS];
  logic           scl_now;
  logic           sda_now;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_seen;
  logic           stop_seen;
  logic [7:0]     idx_next;
  logic [7:0]     cur_byte;
  logic [7:0]     nxt_byte;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds nothing but the second
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sync1_reg    <= 6'h3f;
      sync2_reg    <= 6'h3f;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      sync1_reg    <= {link.scl, link.sda, chip_enable_in, supply_adequate_in,
                       storage_write_select_n_in, target_address_select_in};
      sync2_reg    <= sync1_reg;
      scl_prev_reg <= sync2_reg[5];
      sda_prev_reg <= sync2_reg[4];
    end
  end

  assign scl_now    = sync2_reg[5];
  assign sda_now    = sync2_reg[4];
  assign scl_rise   = scl_now && !scl_prev_reg;
  assign scl_fall   = !scl_now && scl_prev_reg;
  // 400kHz leaves about 125 samples per level, so plain edge detection suffices
  assign start_seen = scl_now && scl_prev_reg && sda_prev_reg && !sda_now; // [RULE14]
  assign stop_seen  = scl_now && scl_prev_reg && !sda_prev_reg && sda_now;

  ////////////////////////////////////////////////////////////////////////
  // read source follows the select level caught at start
  function automatic logic [7:0] read_byte(input logic [7:0] i);
    logic [7:0] r;
    r = 8'h00;
    if (i < NUM_REGS_B) begin
      r = storage_mode_reg ? nvm_mem[i[3:0]] : run_mem[i[3:0]]; // [RULE10] [RULE11]
    end
    return r;
  endfunction

  assign idx_next = idx_reg + 8'h01;
  always_comb cur_byte = read_byte(idx_reg);
  always_comb nxt_byte = read_byte(idx_next);

  ////////////////////////////////////////////////////////////////////////
  // two-wire slave: sample on scl rise, change sda after scl fall
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_reg        <= S_IDLE;
      cnt_reg          <= 4'h0;
      shift_reg        <= 8'h00;
      tx_reg           <= 8'h00;
      idx_reg          <= 8'h00;
      wr_data_reg      <= 8'h00;
      wr_stb_reg       <= 1'b0;
      rw_reg           <= 1'b0;
      storage_mode_reg <= 1'b0;
      enable_t_reg     <= 1'b0;
      supply_t_reg     <= 1'b0;
      link.dev_sda_oe  <= 1'b0;
      link.dev_sda_o   <= 1'b0;
    end else begin
      wr_stb_reg <= 1'b0;
      if (start_seen && config_ready_out) begin // [RULE13]
        state_reg        <= S_ADDR;
        cnt_reg          <= 4'h0;
        link.dev_sda_oe  <= 1'b0;
        storage_mode_reg <= !sync2_reg[1]; // [RULE21] [RULE3]
        enable_t_reg     <= sync2_reg[3];
        supply_t_reg     <= sync2_reg[2];
      end else if (stop_seen) begin
        state_reg       <= S_IDLE;
        link.dev_sda_oe <= 1'b0;
      end else begin
        if (scl_rise) begin
          shift_reg <= {shift_reg[6:0], sda_now};
          cnt_reg   <= cnt_reg + 4'h1;
        end
        if (scl_fall) begin
          unique case (state_reg)
            S_IDLE: begin
            end
            S_ADDR: begin
              if (cnt_reg == 4'h8) begin
                if (shift_reg[7:1] == {TARGET_ADDR_FIXED, sync2_reg[0]}) begin // [RULE19]
                  link.dev_sda_oe <= 1'b1; // [RULE15]
                  rw_reg          <= shift_reg[0];
                  state_reg       <= S_ADDR_ACK;
                end else begin
                  state_reg <= S_IDLE;
                end
              end
            end
            S_ADDR_ACK: begin
              cnt_reg <= 4'h0;
              if (rw_reg) begin
                tx_reg          <= cur_byte; // [RULE20]
                link.dev_sda_oe <= !cur_byte[7];
                state_reg       <= S_RDATA;
              end else begin
                link.dev_sda_oe <= 1'b0;
                state_reg       <= S_INDEX;
              end
            end
            S_INDEX: begin
              if (cnt_reg == 4'h8) begin
                idx_reg         <= shift_reg; // [RULE16]
                link.dev_sda_oe <= 1'b1;
                state_reg       <= S_INDEX_ACK;
              end
            end
            S_INDEX_ACK: begin
              cnt_reg         <= 4'h0;
              link.dev_sda_oe <= 1'b0;
              state_reg       <= S_WDATA;
            end
            S_WDATA: begin
              if (cnt_reg == 4'h8) begin
                wr_stb_reg      <= 1'b1;
                wr_data_reg     <= shift_reg;
                link.dev_sda_oe <= 1'b1;
                state_reg       <= S_WDATA_ACK;
              end
            end
            S_WDATA_ACK: begin
              cnt_reg         <= 4'h0;
              link.dev_sda_oe <= 1'b0;
              idx_reg         <= idx_next;
              state_reg       <= S_WDATA;
            end
            S_RDATA: begin
              if (cnt_reg == 4'h8) begin
                link.dev_sda_oe <= 1'b0;
                state_reg       <= S_RACK;
              end else begin
                tx_reg          <= {tx_reg[6:0], 1'b0};
                link.dev_sda_oe <= !tx_reg[6];
              end
            end
            S_RACK: begin
              cnt_reg <= 4'h0;
              if (shift_reg[0]) begin
                state_reg <= S_IDLE; // [RULE20]
              end else begin
                idx_reg         <= idx_next;
                tx_reg          <= nxt_byte;
                link.dev_sda_oe <= !nxt_byte[7];
                state_reg       <= S_RDATA;
              end
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-on load timer; the link stays deaf until it expires
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      load_cnt_reg     <= '0;
      config_ready_out <= 1'b0;
    end else if (!config_ready_out) begin
      if (load_cnt_reg == LW'(LOAD_CYCLES - 1)) begin
        config_ready_out <= 1'b1; // [RULE13]
      end else begin
        load_cnt_reg <= load_cnt_reg + LW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register banks; reset stands for a factory-fresh storage image
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        nvm_mem[i] <= NVM_DEFAULT[i];
        run_mem[i] <= 8'h00;
      end
    end else if (!config_ready_out) begin
      if (load_cnt_reg == LW'(LOAD_CYCLES - 1)) begin
        for (int i = 0; i < NUM_REGS; i++) begin
          run_mem[i] <= nvm_mem[i]; // [RULE13]
        end
      end
    end else if (wr_stb_reg && idx_reg < NUM_REGS_B) begin
      if (storage_mode_reg) begin
        // enable-high storage writes are unsupported, so they are dropped too
        if (supply_t_reg && !enable_t_reg) begin // [RULE2] [RULE21]
          nvm_mem[idx_reg[3:0]] <= wr_data_reg; // [RULE1]
          run_mem[idx_reg[3:0]] <= wr_data_reg; // [RULE5]
        end
      end else if (idx_reg <= IDX_VOUT_LAST || !enable_t_reg) begin // [RULE8] [RULE7]
        run_mem[idx_reg[3:0]] <= wr_data_reg; // [RULE6]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration fields handed to the converters
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      phase_select_out    <= 2'h0;
      uvlo_low_select_out <= 1'b0;
    end else begin
      phase_select_out    <= run_mem[IDX_FREQ_PHASE][PHASE_MSB:PHASE_LSB]; // [RULE17]
      uvlo_low_select_out <= run_mem[IDX_PWR][UVLO_BIT]; // [RULE18]
    end
  end

endmodule

//--- logic/inc_host.sv
// host master: APB command registers driving two-wire register writes and reads
//
// Implementation choices: the APB register port and the placing of the registers.
module inc_host
  import inc_pkg::*;
#(
  parameter int POR_CYCLES = NVM_LOAD_CYCLES,
  parameter int GAP_CYCLES = NVM_GAP_CYCLES,
  parameter int QUARTER    = SCL_QUARTER_CYCLES
) (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        chip_enable_in,
  input  wire logic        supply_adequate_in,
  output logic             storage_write_select_n_out,
  output logic             target_address_select_out,
  inc_if.host              link
);

  localparam int PW = $clog2(POR_CYCLES + 1);
  localparam int GW = $clog2(GAP_CYCLES + 1);
  localparam int QW = $clog2(QUARTER + 1);

  typedef enum logic [2:0] {H_IDLE, H_WAIT, H_START, H_BIT, H_STOP} inc_hstate_e;

  inc_hstate_e  state_reg;
  logic [2:0]   sync1_reg;
  logic [2:0]   sync2_reg;
  logic [7:0]   idx_reg;
  logic [7:0]   wdata_reg;
  logic         rd_reg;
  logic         stor_reg;
  logic         go_reg;
  logic         busy_reg;
  logic         nack_reg;
  logic         refused_reg;
  logic [7:0]   rdata_reg;
  logic [PW-1:0] por_cnt_reg;
  logic         por_done_reg;
  logic [GW-1:0] gap_cnt_reg;
  logic [QW-1:0] qcnt_reg;
  logic [1:0]   q_reg;
  logic [3:0]   bit_reg;
  logic [1:0]   byte_reg;
  logic [7:0]   tx_reg;
  logic [8:0]   rx_reg;
  logic         tick;
  logic         rx_byte;
  logic         apb_wr;
  logic         bad_cmd;

  assign tick    = (qcnt_reg == QW'(QUARTER - 1));
  assign rx_byte = rd_reg && byte_reg == 2'h3;
  assign apb_wr  = psel_in && penable_in && pready_out && pwrite_in;
  // storage access needs enable low and good supply; run-time writes above 02h need enable low
  assign bad_cmd = (stor_reg && (sync2_reg[1] || !sync2_reg[0])) // [RULE2] [RULE9] [RULE12]
                || (!stor_reg && !rd_reg && idx_reg > IDX_VOUT_LAST && sync2_reg[1]); // [RULE7]

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for sda, chip enable and supply status
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sync1_reg <= 3'h4;
      sync2_reg <= 3'h4;
    end else begin
      sync1_reg <= {link.sda, chip_enable_in, supply_adequate_in};
      sync2_reg <= sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave, no wait states: answer is prepared in the setup cycle
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
      idx_reg     <= 8'h00;
      wdata_reg   <= 8'h00;
      rd_reg      <= 1'b0;
      stor_reg    <= 1'b0;
      go_reg      <= 1'b0;
      target_address_select_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      go_reg     <= 1'b0;
      prdata_out <= 32'h0;
      if (psel_in && !penable_in && !pwrite_in) begin
        unique case (paddr_in)
          HOST_CMD_OFS:    prdata_out[CMD_ASEL_BIT:CMD_READ_BIT] <= {target_address_select_out, stor_reg, rd_reg};
          HOST_INDEX_OFS:  prdata_out[7:0] <= idx_reg;
          HOST_WDATA_OFS:  prdata_out[7:0] <= wdata_reg;
          HOST_STATUS_OFS: prdata_out[STAT_RDATA_LSB+7:0] <= {rdata_reg, 4'h0, por_done_reg,
                                                              refused_reg, nack_reg, busy_reg};
          default:         prdata_out <= 32'h0;
        endcase
      end
      // command fields are frozen while a transfer runs
      if (apb_wr && !busy_reg) begin
        unique case (paddr_in)
          HOST_CMD_OFS: begin
            rd_reg                    <= pwdata_in[CMD_READ_BIT];
            stor_reg                  <= pwdata_in[CMD_STORAGE_BIT];
            target_address_select_out <= pwdata_in[CMD_ASEL_BIT];
            go_reg                    <= pwdata_in[CMD_GO_BIT];
          end
          HOST_INDEX_OFS: idx_reg   <= pwdata_in[7:0];
          HOST_WDATA_OFS: wdata_reg <= pwdata_in[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-on wait and storage write spacing
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      por_cnt_reg  <= '0;
      por_done_reg <= 1'b0;
      gap_cnt_reg  <= '0;
    end else begin
      if (!por_done_reg) begin
        por_cnt_reg  <= por_cnt_reg + PW'(1);
        por_done_reg <= (por_cnt_reg == PW'(POR_CYCLES - 1)); // [RULE13]
      end
      if (state_reg == H_STOP && tick && q_reg == 2'h3 && stor_reg && !rd_reg) begin
        gap_cnt_reg <= GW'(GAP_CYCLES); // [RULE4]
      end else if (gap_cnt_reg != '0) begin
        gap_cnt_reg <= gap_cnt_reg - GW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-wire master; each bit is four quarter periods of scl
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_reg        <= H_IDLE;
      busy_reg         <= 1'b0;
      nack_reg         <= 1'b0;
      refused_reg      <= 1'b0;
      rdata_reg        <= 8'h00;
      qcnt_reg         <= '0;
      q_reg            <= 2'h0;
      bit_reg          <= 4'h0;
      byte_reg         <= 2'h0;
      tx_reg           <= 8'h00;
      rx_reg           <= 9'h000;
      link.host_scl_oe <= 1'b0;
      link.host_sda_oe <= 1'b0;
      link.host_scl_o  <= 1'b0;
      link.host_sda_o  <= 1'b0;
      storage_write_select_n_out <= 1'b1;
    end else begin
      qcnt_reg <= (state_reg == H_IDLE || state_reg == H_WAIT || tick) ? '0 : qcnt_reg + QW'(1);
      if (state_reg != H_IDLE && state_reg != H_WAIT && tick) begin
        q_reg <= q_reg + 2'h1;
      end
      unique case (state_reg)
        H_IDLE: begin
          if (go_reg && por_done_reg) begin
            nack_reg    <= 1'b0;
            refused_reg <= bad_cmd;
            if (!bad_cmd) begin
              busy_reg                   <= 1'b1;
              storage_write_select_n_out <= !stor_reg; // [RULE3]
              state_reg                  <= H_WAIT;
            end
          end
        end
        H_WAIT: begin
          if (!stor_reg || rd_reg || gap_cnt_reg == '0) begin // [RULE4]
            q_reg     <= 2'h0;
            byte_reg  <= 2'h0;
            state_reg <= H_START;
          end
        end
        H_START: begin
          if (tick) begin
            unique case (q_reg)
              2'h0: link.host_sda_oe <= 1'b0;
              2'h1: link.host_scl_oe <= 1'b0;
              2'h2: link.host_sda_oe <= 1'b1;
              2'h3: begin
                link.host_scl_oe <= 1'b1;
                bit_reg          <= 4'h0;
                tx_reg           <= {TARGET_ADDR_FIXED, target_address_select_out, byte_reg[1]}; // [RULE20]
                state_reg        <= H_BIT;
              end
            endcase
          end
        end
        H_BIT: begin
          if (tick) begin
            unique case (q_reg)
              2'h0: link.host_sda_oe <= !(bit_reg == 4'h8 || rx_byte || tx_reg[7]);
              2'h1: link.host_scl_oe <= 1'b0; // [RULE14]
              2'h2: rx_reg <= {rx_reg[7:0], sync2_reg[2]};
              2'h3: begin
                link.host_scl_oe <= 1'b1;
                tx_reg           <= {tx_reg[6:0], 1'b0};
                bit_reg          <= bit_reg + 4'h1;
                if (bit_reg == 4'h8) begin
                  bit_reg <= 4'h0;
                  if (!rx_byte && rx_reg[0]) begin
                    nack_reg  <= 1'b1;
                    state_reg <= H_STOP;
                  end else if (byte_reg == 2'h0) begin
                    byte_reg <= 2'h1;
                    tx_reg   <= idx_reg; // [RULE16]
                  end else if (byte_reg == 2'h1 && !rd_reg) begin
                    byte_reg <= 2'h2;
                    tx_reg   <= wdata_reg;
                  end else if (byte_reg == 2'h1) begin
                    byte_reg  <= 2'h2;
                    state_reg <= H_START; // [RULE20]
                  end else if (byte_reg == 2'h2 && rd_reg) begin
                    byte_reg <= 2'h3;
                  end else begin
                    if (rx_byte) begin
                      rdata_reg <= rx_reg[8:1];
                    end
                    state_reg <= H_STOP;
                  end
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            unique case (q_reg)
              2'h0: link.host_sda_oe <= 1'b1;
              2'h1: link.host_scl_oe <= 1'b0;
              2'h2: link.host_sda_oe <= 1'b0;
              2'h3: begin
                busy_reg                   <= 1'b0;
                storage_write_select_n_out <= 1'b1;
                state_reg                  <= H_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

endmodule

//--- tb/inc_sva.sv
// checker for the two-wire link between host master and configuration target
module inc_sva (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////
  // target moves sda only with scl low, else its data would look like start or stop
  AST_DEV_LOW: assert property ($changed(dev_sda_oe) |-> !scl) else $error("sda moved, scl high");
  AST_ACK_HOLD: assert property (dev_sda_oe && $rose(scl) |-> dev_sda_oe [*8]) else $error("ack short");
  AST_STOP_REL: assert property ($fell(host_sda_oe) && scl |-> sda) else $error("sda held at stop");
  AST_IDLE: assert property (scl && $rose(sda) |=> !dev_sda_oe [*8]) else $error("busy after stop");
  AST_START: assert property ($fell(sda) && scl |-> scl [*8]) else $error("start hold short");
  AST_CLASH: assert property ($changed(host_sda_oe) && scl |-> !dev_sda_oe) else $error("bus clash");
  AST_SCL_HI: assert property ($rose(scl) |-> scl [*8]) else $error("scl high short");
  AST_SCL_LO: assert property ($rose(host_scl_oe) |-> !scl [*8]) else $error("scl low short");
endmodule

//--- tb/tb_i2c_nvm_config_access.sv
// bench: host master drives the configuration target over the two-wire link
module tb_i2c_nvm_config_access;
  import inc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  localparam int GAP = 2000;
  logic        en = 1'b0, sup = 1'b1, asel = 1'b0, prdy, wsn, uv, rdy, hasel;
  logic [1:0]  ph;
  logic [7:0]  pa = 8'h00, d, v;
  logic [31:0] pwd = 32'h0, prd, st;
  int          error_cnt = 0, checks = 0, cyc = 0, t0 = 0;
  inc_if inc_if_inst ();
  // short load and storage gap keep the run small; scl keeps its real rate
  inc_host #(.POR_CYCLES(200), .GAP_CYCLES(GAP)) inc_host_inst (.ref_clk_in(clk), .reset_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(), .chip_enable_in(en), .supply_adequate_in(sup), .storage_write_select_n_out(wsn),
    .target_address_select_out(hasel), .link(inc_if_inst.host));
  inc_dev #(.LOAD_CYCLES(200)) inc_dev_inst (.ref_clk_in(clk), .reset_in(rst), .link(inc_if_inst.dev),
    .chip_enable_in(en), .supply_adequate_in(sup), .storage_write_select_n_in(wsn), .target_address_select_in(asel),
    .phase_select_out(ph), .uvlo_low_select_out(uv), .config_ready_out(rdy));
  inc_sva inc_sva_inst (.ref_clk_in(clk), .reset_in(rst), .scl(inc_if_inst.scl), .sda(inc_if_inst.sda),
    .host_scl_oe(inc_if_inst.host_scl_oe), .host_sda_oe(inc_if_inst.host_sda_oe),
    .dev_sda_oe(inc_if_inst.dev_sda_oe));
  ////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  function automatic logic [3:0] sts(input logic nk, rf);
    sts = {1'b1, rf, nk, 1'b0};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    st = prd;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic xf(input logic [3:0] cmd, input logic [7:0] idx, wd, input logic [3:0] es);
    apb(1'b1, HOST_INDEX_OFS, {24'h0, idx});
    apb(1'b1, HOST_WDATA_OFS, {24'h0, wd});
    apb(1'b1, HOST_CMD_OFS, {28'h0, cmd});
    repeat (3) @(posedge clk);
    do apb(1'b0, HOST_STATUS_OFS, 32'h0); while (st[STAT_BUSY_BIT] !== 1'b0);
    chk(st[3:0], es);
  endtask
  initial begin
    void'($urandom(60942));
    d = 8'($urandom);
    v = 8'($urandom);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    while (rdy !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    chk(ph, NVM_DEFAULT[9][6:5]);
    chk(uv, NVM_DEFAULT[10][6]);
    xf(4'h1, 8'h09, v, sts(0, 0));
    chk(ph, v[6:5]);
    en <= 1'b1;
    xf(4'h1, 8'h01, d, sts(0, 0));
    xf(4'h3, 8'h01, 8'h00, sts(0, 0));
    chk(st[15:8], d);
    xf(4'h1, 8'h0a, ~v, sts(0, 1));
    en <= 1'b0;
    sup <= 1'b0;
    xf(4'h5, 8'h0a, ~v, sts(0, 1));
    sup <= 1'b1;
    xf(4'h5, 8'h0a, v, sts(0, 0));
    chk(uv, v[6]);
    // a second storage write at once must sit out the spacing before it starts
    t0 = cyc;
    xf(4'h5, 8'h0a, v, sts(0, 0));
    chk(cyc - t0 > GAP / 2 + 116 * SCL_QUARTER_CYCLES, 1);
    xf(4'h7, 8'h0a, 8'h00, sts(0, 0));
    chk(st[15:8], v);
    asel <= 1'b1;
    xf(4'h3, 8'h01, 8'h00, sts(1, 0));
    xf(4'hb, 8'h01, 8'h00, sts(0, 0));
    chk(st[15:8], d);
    chk(hasel, 1'b1);
    end_of_test();
  end
endmodule
